// [logic/can_xcvr_mode.v]
// mode state machine for the bus transceiver of a system basis chip, with wishbone registers
// assumes synchronous inputs, bus wake and pattern detectors supplied from outside
`timescale 1ns/1ps
`include "can_xcvr_defs.vh"

// Contract
// - enter active only with mode control set and chip in normal or flash
// - leave active at once when either entry condition drops
// - data passes only in active; supply enabled there
// - off-line: only low-power receiver and termination powered, rest off except supply while keep-on set
// - on-line states: supply and normal termination on, tx and rx off
// - tx disable in active stops forwarding tx, receiver still delivers
// - loopback with tx disabled routes tx input to rx output
// - go on-line when leaving active, or on wake in on-line or in off-line without partial net
// - in on-line any wake timing pattern gives a wake event
// - on-line goes off-line after configured bus silence
// - select bit picks duration; wake entry uses fixed long duration
// - wake in on-line, or in off-line without partial net, forces on-line, sets flag, drives rx low
// - partial networking selects listen state, ordinary traffic no wake
// - listen timer restarts on each bus event, expiry goes off-line
// - with partial net, a wake pattern in off-line returns to listen silently
// - special pattern in listen enters on-line and performs wake-up
// - global wake accepted only within window after initial or entry from off-line
// - partial net bit clears on wake, active, supply failure, fail-safe
// - after power-on reset start off-line
// - supply failure sets tx disable, clears keep-on and partial net
// - keep-on bit holds supply on even off-line
module can_xcvr_mode #(
    parameter [31:0] OFF_SHORT_CYC = `US_TO_CYC(`T_OFF_SHORT_US),
    parameter [31:0] OFF_LONG_CYC  = `US_TO_CYC(`T_OFF_LONG_US),
    parameter [31:0] OFF_WAKE_CYC  = `US_TO_CYC(`T_OFF_WAKE_US),
    parameter [31:0] GWAKE_CYC     = `US_TO_CYC(`T_GWAKE_US)
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        chip_normal_i,
    input  wire        chip_flash_i,
    input  wire        chip_failsafe_i,
    input  wire        supply_fail_i,
    input  wire        tx_in_pin_i,
    input  wire        bus_rx_i,
    input  wire        bus_event_i,
    input  wire        bus_wake_i,
    input  wire        initial_msg_i,
    input  wire        global_wake_i,
    output reg         rx_out_pin_o,
    output reg         bus_tx_o,
    output reg         tx_en_o,
    output reg         rx_en_o,
    output reg         lp_rx_en_o,
    output reg         lp_term_en_o,
    output reg         term_en_o,
    output reg         transceiver_supply_o,
    output reg         wake_pulse_o
);

    localparam [3:0] S_ACTIVE  = `ST_ACTIVE;
    localparam [3:0] S_ONLINE  = `ST_ONLINE;
    localparam [3:0] S_LISTEN  = `ST_LISTEN;
    localparam [3:0] S_OFFLINE = `ST_OFFLINE;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [31:0] off_cnt;
    reg  [31:0] next_off_cnt;
    reg  [31:0] gw_cnt;
    reg  [31:0] next_gw_cnt;
    reg         wake_long;
    reg         next_wake_long;
    reg         transceiver_mode_ctrl;
    reg         tx_disable;
    reg         rx_loopback;
    reg         partial_net_en;
    reg         offline_time_sel;
    reg         supply_keep_on;
    reg         bus_wake_flag;
    reg         wake_now;
    reg         next_tx_en;
    reg         next_rx_en;
    reg         next_lp_rx_en;
    reg         next_lp_term_en;
    reg         next_term_en;
    reg         next_supply;
    reg         next_bus_tx;
    reg         next_rx_out;
    reg  [31:0] next_rd_data;

    wire active_ok = transceiver_mode_ctrl & (chip_normal_i | chip_flash_i);
    wire wr_hit    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    wire rd_hit    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    wire ctrl_adr  = (wb_adr_i == `REG_CTRL);
    wire stat_adr  = (wb_adr_i == `REG_STAT);
    wire ctrl_wr   = wr_hit & ctrl_adr & wb_sel_i[0];
    wire stat_wr   = wr_hit & stat_adr & wb_sel_i[0];
    wire entering_active = (next_state == S_ACTIVE) & (state != S_ACTIVE);
    // a failing supply cuts the driver at once, ahead of the disable bit
    wire tx_block  = tx_disable | supply_fail_i;
    wire pn_clear  = wake_now | entering_active | chip_failsafe_i | supply_fail_i;
    wire [31:0] ctrl_rd_word = {26'h0, supply_keep_on, offline_time_sel, partial_net_en,
                                rx_loopback, tx_disable, transceiver_mode_ctrl};
    wire [31:0] stat_rd_word = {27'h0, bus_wake_flag, state};

    // off-line duration in force
    function [31:0] off_limit;
        input sel;
        input from_wake;
        begin
            if (from_wake)
                off_limit = OFF_WAKE_CYC;
            else if (sel)
                off_limit = OFF_LONG_CYC;
            else
                off_limit = OFF_SHORT_CYC;
        end
    endfunction

    // silence timer reaches its limit on this cycle
    function timer_done;
        input [31:0] cnt;
        input [31:0] limit;
        begin
            timer_done = (cnt + 32'h1 >= limit);
        end
    endfunction

    // controller data reaches the bus only in active with the driver free
    function drives_bus;
        input [3:0] st;
        input       blocked;
        begin
            drives_bus = (st == S_ACTIVE) & ~blocked;
        end
    endfunction

    // wake window counts down to zero and rests there
    function [31:0] count_down;
        input [31:0] cnt;
        begin
            count_down = (cnt != 32'h0) ? cnt - 32'h1 : 32'h0;
        end
    endfunction

    always @* begin
        next_state     = state;
        next_off_cnt   = off_cnt;
        next_gw_cnt    = count_down(gw_cnt);
        next_wake_long = wake_long;
        wake_now       = 1'b0;
        case (state)
            S_ACTIVE: begin
                if (!active_ok) begin
                    next_state     = S_ONLINE;
                    next_off_cnt   = 32'h0;
                    next_wake_long = 1'b0;
                end
            end
            S_ONLINE: begin
                if (active_ok) begin
                    next_state = S_ACTIVE;
                end else if (bus_wake_i) begin
                    wake_now       = 1'b1;
                    next_off_cnt   = 32'h0;
                    next_wake_long = 1'b1;
                end else if (bus_event_i) begin
                    next_off_cnt = 32'h0;
                end else if (timer_done(off_cnt, off_limit(offline_time_sel, wake_long))) begin
                    next_state = S_OFFLINE;
                end else begin
                    next_off_cnt = off_cnt + 32'h1;
                end
                if (partial_net_en && !active_ok && !bus_wake_i) begin
                    next_state   = S_LISTEN;
                    next_off_cnt = 32'h0;
                    next_gw_cnt  = 32'h0;
                end
            end
            S_LISTEN: begin
                if (initial_msg_i)
                    next_gw_cnt = GWAKE_CYC;
                if (active_ok) begin
                    next_state = S_ACTIVE;
                end else if (global_wake_i && gw_cnt != 32'h0) begin
                    next_state     = S_ONLINE;
                    wake_now       = 1'b1;
                    next_off_cnt   = 32'h0;
                    next_wake_long = 1'b1;
                end else if (!partial_net_en) begin
                    next_state   = S_ONLINE;
                    next_off_cnt = 32'h0;
                end else if (bus_event_i) begin
                    next_off_cnt = 32'h0;
                end else if (timer_done(off_cnt, off_limit(offline_time_sel, 1'b0))) begin
                    next_state = S_OFFLINE;
                end else begin
                    next_off_cnt = off_cnt + 32'h1;
                end
            end
            S_OFFLINE: begin
                next_off_cnt = 32'h0;
                if (active_ok) begin
                    next_state = S_ACTIVE;
                end else if (bus_wake_i) begin
                    if (partial_net_en) begin
                        next_state  = S_LISTEN;
                        next_gw_cnt = GWAKE_CYC;
                    end else begin
                        next_state     = S_ONLINE;
                        wake_now       = 1'b1;
                        next_wake_long = 1'b1;
                    end
                end
            end
            default: begin
                next_state = S_OFFLINE;
            end
        endcase
    end

    // state, silence timer and wake window
    always @(posedge clk_i) begin
        if (rst_i) begin
            state          <= S_OFFLINE;
            off_cnt        <= 32'h0;
            gw_cnt         <= 32'h0;
            wake_long      <= 1'b0;
            wake_pulse_o   <= 1'b0;
        end else begin
            state          <= next_state;
            off_cnt        <= next_off_cnt;
            gw_cnt         <= next_gw_cnt;
            wake_long      <= next_wake_long;
            wake_pulse_o   <= wake_now;
        end
    end

    // control and status registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            transceiver_mode_ctrl <= 1'b0;
            tx_disable            <= 1'b0;
            rx_loopback           <= 1'b0;
            partial_net_en        <= 1'b0;
            offline_time_sel      <= 1'b0;
            supply_keep_on        <= 1'b0;
            bus_wake_flag         <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                transceiver_mode_ctrl <= wb_dat_i[`CTRL_MODE_BIT];
                tx_disable            <= wb_dat_i[`CTRL_TXDIS_BIT];
                rx_loopback           <= wb_dat_i[`CTRL_LOOP_BIT];
                partial_net_en        <= wb_dat_i[`CTRL_PN_BIT];
                offline_time_sel      <= wb_dat_i[`CTRL_OTSEL_BIT];
                supply_keep_on        <= wb_dat_i[`CTRL_KEEP_BIT];
            end
            if (pn_clear)
                partial_net_en <= 1'b0;
            if (supply_fail_i) begin
                tx_disable     <= 1'b1;
                supply_keep_on <= 1'b0;
            end
            // write one to clear; a new wake wins
            if (stat_wr && wb_dat_i[`STAT_WAKE_BIT])
                bus_wake_flag <= 1'b0;
            if (wake_now)
                bus_wake_flag <= 1'b1;
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        next_rd_data = 32'h0;
        if (rd_hit) begin
            case (wb_adr_i)
                `REG_CTRL: next_rd_data = ctrl_rd_word;
                `REG_STAT: next_rd_data = stat_rd_word;
                default:   next_rd_data = 32'h0;
            endcase
        end
    end

    // wishbone answer one cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= next_rd_data;
        end
    end

    // analog enables and pin paths for the state about to be entered
    always @* begin
        next_tx_en      = drives_bus(next_state, tx_block);
        next_rx_en      = (next_state == S_ACTIVE);
        next_lp_rx_en   = (next_state != S_ACTIVE);
        next_lp_term_en = (next_state == S_OFFLINE);
        next_term_en    = (next_state != S_OFFLINE);
        next_supply     = (next_state != S_OFFLINE) | supply_keep_on;
        next_bus_tx     = 1'b1;
        next_rx_out     = ~(bus_wake_flag | wake_now);
        if (next_tx_en)
            next_bus_tx = tx_in_pin_i;
        if (next_state == S_ACTIVE) begin
            if (tx_disable && rx_loopback)
                next_rx_out = tx_in_pin_i;
            else
                next_rx_out = bus_rx_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_o              <= 1'b0;
            rx_en_o              <= 1'b0;
            lp_rx_en_o           <= 1'b1;
            lp_term_en_o         <= 1'b1;
            term_en_o            <= 1'b0;
            transceiver_supply_o <= 1'b0;
            bus_tx_o             <= 1'b1;
            rx_out_pin_o         <= 1'b1;
        end else begin
            tx_en_o              <= next_tx_en;
            rx_en_o              <= next_rx_en;
            lp_rx_en_o           <= next_lp_rx_en;
            lp_term_en_o         <= next_lp_term_en;
            term_en_o            <= next_term_en;
            transceiver_supply_o <= next_supply;
            bus_tx_o             <= next_bus_tx;
            rx_out_pin_o         <= next_rx_out;
        end
    end

endmodule

// [logic/can_xcvr_defs.vh]
// constants for the transceiver mode state machine: register map, fields, timing
// assumes a 250 MHz system clock and classic wishbone byte addressing
`ifndef CAN_XCVR_DEFS_VH
`define CAN_XCVR_DEFS_VH

`define CLK_MHZ          250
// register byte offsets
`define REG_CTRL         4'h0
`define REG_STAT         4'h4
// control register fields
`define CTRL_MODE_BIT    0
`define CTRL_TXDIS_BIT   1
`define CTRL_LOOP_BIT    2
`define CTRL_PN_BIT      3
`define CTRL_OTSEL_BIT   4
`define CTRL_KEEP_BIT    5
`define CTRL_RESET       6'h00
// status register fields
`define STAT_WAKE_BIT    4
// off-line durations in microseconds
`define T_OFF_SHORT_US   32'd400
`define T_OFF_LONG_US    32'd4000
`define T_OFF_WAKE_US    32'd8000
// global wake timeout window in microseconds
`define T_GWAKE_US       32'd1000
`define US_TO_CYC(t)     ((t) * `CLK_MHZ)
// one-hot states
`define ST_ACTIVE        4'h1
`define ST_ONLINE        4'h2
`define ST_LISTEN        4'h4
`define ST_OFFLINE       4'h8
`endif

// [testbench/can_xcvr_mode_props.sv]
// checker for the transceiver mode machine, bound to its top module
// assumes rising clk_i, rst_i synchronous active high
`timescale 1ns/1ps
module can_xcvr_mode_props #(
    parameter [31:0] OFF_SHORT_CYC = 32'd20
) (
    input wire clk_i,
    input wire rst_i,
    input wire chip_normal_i,
    input wire chip_flash_i,
    input wire supply_fail_i,
    input wire bus_event_i,
    input wire bus_wake_i,
    input wire global_wake_i,
    input wire bus_tx_o,
    input wire tx_en_o,
    input wire rx_en_o,
    input wire lp_rx_en_o,
    input wire lp_term_en_o,
    input wire term_en_o,
    input wire transceiver_supply_o,
    input wire wake_pulse_o
);
    reg [31:0] sil;
    // cycles of bus silence in on-line and listen
    always @(posedge clk_i) begin
        if (rst_i || bus_event_i || rx_en_o || !term_en_o)
            sil <= 32'h0;
        else
            sil <= sil + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_entry; $rose(rx_en_o) |-> $past(chip_normal_i || chip_flash_i); endproperty
    a_entry: assert property (p_entry) else $error("active without chip mode");
    property p_leave; rx_en_o && !chip_normal_i && !chip_flash_i |=> !rx_en_o; endproperty
    a_leave: assert property (p_leave) else $error("active kept");
    property p_txact; tx_en_o |-> rx_en_o && transceiver_supply_o; endproperty
    a_txact: assert property (p_txact) else $error("tx outside active");
    property p_off; lp_term_en_o |-> !tx_en_o && !rx_en_o && !term_en_o && lp_rx_en_o; endproperty
    a_off: assert property (p_off) else $error("off-line power");
    property p_onl; term_en_o && !rx_en_o |-> transceiver_supply_o && !tx_en_o && lp_rx_en_o; endproperty
    a_onl: assert property (p_onl) else $error("on-line power");
    property p_txdis; !tx_en_o && !$past(tx_en_o) |-> bus_tx_o; endproperty
    a_txdis: assert property (p_txdis) else $error("bus driven");
    property p_wkst; wake_pulse_o |-> term_en_o && !rx_en_o && transceiver_supply_o; endproperty
    a_wkst: assert property (p_wkst) else $error("wake not on-line");
    property p_wkc; wake_pulse_o |-> $past(bus_wake_i || global_wake_i); endproperty
    a_wkc: assert property (p_wkc) else $error("wake without cause");
    property p_rst; $fell(rst_i) |-> lp_term_en_o && !transceiver_supply_o && !wake_pulse_o; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_tmr; $rose(lp_term_en_o) |-> sil >= OFF_SHORT_CYC - 32'd2; endproperty
    a_tmr: assert property (p_tmr) else $error("off-line too early");
    property p_fail; supply_fail_i |=> !tx_en_o; endproperty
    a_fail: assert property (p_fail) else $error("tx after failure");
endmodule
bind can_xcvr_mode can_xcvr_mode_props #(.OFF_SHORT_CYC(OFF_SHORT_CYC)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .chip_normal_i(chip_normal_i), .chip_flash_i(chip_flash_i),
    .supply_fail_i(supply_fail_i), .bus_event_i(bus_event_i), .bus_wake_i(bus_wake_i),
    .global_wake_i(global_wake_i), .bus_tx_o(bus_tx_o), .tx_en_o(tx_en_o), .rx_en_o(rx_en_o),
    .lp_rx_en_o(lp_rx_en_o), .lp_term_en_o(lp_term_en_o), .term_en_o(term_en_o),
    .transceiver_supply_o(transceiver_supply_o), .wake_pulse_o(wake_pulse_o));

// [testbench/can_bus_partner.sv]
// model of the other bus nodes: traffic, wake and wake-message pulses
// assumes callers enter its tasks right after a rising edge
`timescale 1ns/1ps
module can_bus_partner (
    input  wire       clk_i,
    input  wire       bus_tx_i,
    output reg  [3:0] ev_o,
    output wire       bus_rx_o
);
    // only this node drives; bus recessive high otherwise
    assign bus_rx_o = (bus_tx_i === 1'b0) ? 1'b0 : 1'b1;
    initial ev_o = 4'h0;
    // bit0 event, bit1 wake pattern, bit2 initial, bit3 global
    task send(input [3:0] k);
        begin
            ev_o <= k;
            @(posedge clk_i);
            ev_o <= 4'h0;
        end
    endtask
    task wake_seq;
        begin
            send(4'h5);
            repeat (3) @(posedge clk_i);
            send(4'h9);
        end
    endtask
endmodule

// [testbench/can_transceiver_mode_fsm_tb.sv]
// self-checking bench for the transceiver mode machine
// assumes shortened off-line counts and the bus partner model
`timescale 1ns/1ps
`include "can_xcvr_defs.vh"
module can_transceiver_mode_fsm_tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [3:0]  adr = 4'h0;
    reg  [31:0] wdat = 32'h0;
    reg         we = 1'b0;
    reg         stb = 1'b0;
    reg         normal = 1'b0;
    reg         sfail = 1'b0;
    reg         txin = 1'b1;
    reg         flash = 1'b0;
    reg         fsafe = 1'b0;
    reg  [3:0]  sel = 4'hF;
    reg  [31:0] q;
    wire [31:0] rdat;
    wire [3:0]  ev;
    wire        ack, rx_out, bus_tx, tx_en, rx_en, lp_rx, lp_term, term, supply, wake, bus_rx;
    integer     miscompares = 0;
    integer     n_compared = 0;
    integer     cyc_n = 0;
    integer     n_wake = 0;
    can_xcvr_mode #(.OFF_SHORT_CYC(20), .OFF_LONG_CYC(40), .OFF_WAKE_CYC(60), .GWAKE_CYC(30)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .chip_normal_i(normal),
        .chip_flash_i(flash), .chip_failsafe_i(fsafe), .supply_fail_i(sfail), .tx_in_pin_i(txin),
        .bus_rx_i(bus_rx), .bus_event_i(ev[0]), .bus_wake_i(ev[1]), .initial_msg_i(ev[2]),
        .global_wake_i(ev[3]), .rx_out_pin_o(rx_out), .bus_tx_o(bus_tx), .tx_en_o(tx_en), .rx_en_o(rx_en),
        .lp_rx_en_o(lp_rx), .lp_term_en_o(lp_term), .term_en_o(term), .transceiver_supply_o(supply),
        .wake_pulse_o(wake));
    can_bus_partner i_bus (.clk_i(clk_i), .bus_tx_i(bus_tx), .ev_o(ev), .bus_rx_o(bus_rx));
    initial forever #2 clk_i = ~clk_i;
    // one-cycle wake pulses, counted as they stand
    always @(posedge clk_i) n_wake <= n_wake + wake;
    task stop_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s exp %0h seen %0h", nm, exp, seen);
            end
        end
    endtask
    task wb(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk_i);
            while (ack !== 1'b1)
                @(posedge clk_i);
            q = rdat;
            stb <= 1'b0;
        end
    endtask
    task rd(input string nm, input [3:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0);
            chk(nm, q, e);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    initial begin
        tick(12);
        rst_i <= 1'b0;
        rd("stat", `REG_STAT, 32'h8);
        chk("lp_term", lp_term, 1);
        rd("unmapped", 4'h8, 0);
        sel <= 4'h0;
        wb(1'b1, `REG_CTRL, 32'h1);
        sel <= 4'hF;
        rd("no lane", `REG_CTRL, 32'h0);
        wb(1'b1, `REG_CTRL, 32'h1);
        tick(2);
        rd("stat", `REG_STAT, 32'h8);
        normal <= 1'b1;
        tick(2);
        rd("stat", `REG_STAT, 32'h1);
        chk("supply", supply, 1);
        wb(1'b1, `REG_CTRL, 32'h7);
        txin <= 1'b0;
        tick(2);
        chk("loop rx", rx_out, 0);
        chk("bus_tx", bus_tx, 1);
        chk("rx_en", rx_en, 1);
        chk("tx_en", tx_en, 0);
        wb(1'b1, `REG_CTRL, 32'h1);
        tick(2);
        chk("bus_tx", bus_tx, 0);
        txin <= 1'b1;
        $display("active done");
        normal <= 1'b0;
        tick(10);
        chk("term", term, 1);
        rd("stat", `REG_STAT, 32'h2);
        chk("lp_rx", lp_rx, 1);
        tick(50);
        rd("stat", `REG_STAT, 32'h8);
        i_bus.send(4'h3);
        tick(2);
        chk("rx_out", rx_out, 0);
        rd("stat", `REG_STAT, 32'h12);
        chk("wakes", n_wake, 1);
        wb(1'b1, `REG_STAT, 32'h10);
        rd("stat", `REG_STAT, 32'h2);
        tick(40);
        chk("lp_term", lp_term, 0);
        $display("wake done");
        wb(1'b1, `REG_CTRL, 32'h8);
        i_bus.send(4'h3);
        tick(2);
        rd("stat", `REG_STAT, 32'h4);
        repeat (5) begin
            tick(10);
            i_bus.send(4'h1);
        end
        rd("stat", `REG_STAT, 32'h4);
        tick(50);
        rd("stat", `REG_STAT, 32'h8);
        i_bus.send(4'h3);
        tick(2);
        rd("stat", `REG_STAT, 32'h4);
        chk("wakes", n_wake, 1);
        i_bus.wake_seq;
        tick(2);
        rd("stat", `REG_STAT, 32'h12);
        chk("wakes", n_wake, 2);
        rd("ctrl", `REG_CTRL, 32'h0);
        wb(1'b1, `REG_STAT, 32'h10);
        wb(1'b1, `REG_CTRL, 32'h8);
        repeat (4) begin
            tick(10);
            i_bus.send(4'h1);
        end
        i_bus.send(4'h8);
        tick(2);
        rd("stat", `REG_STAT, 32'h4);
        chk("wakes", n_wake, 2);
        fsafe <= 1'b1;
        tick(1);
        fsafe <= 1'b0;
        rd("ctrl", `REG_CTRL, 32'h0);
        $display("listen done");
        wb(1'b1, `REG_CTRL, 32'h28);
        sfail <= 1'b1;
        tick(1);
        sfail <= 1'b0;
        tick(2);
        rd("ctrl", `REG_CTRL, 32'h2);
        flash <= 1'b1;
        wb(1'b1, `REG_CTRL, 32'h9);
        tick(2);
        rd("ctrl", `REG_CTRL, 32'h1);
        chk("tx_en", tx_en, 1);
        sfail <= 1'b1;
        tick(1);
        sfail <= 1'b0;
        tick(1);
        chk("tx_en", tx_en, 0);
        rd("ctrl", `REG_CTRL, 32'h3);
        flash <= 1'b0;
        wb(1'b1, `REG_CTRL, 32'h20);
        tick(70);
        chk("lp_term", lp_term, 1);
        chk("supply", supply, 1);
        $display("supply done");
        stop_test;
    end
endmodule
